//--- src/slpo_pkg.sv
/*
  Package for the status lamp pattern and magnetic override block.
  Holds register offsets, reset values, timing constants and shared types.
  Assumes a 100 MHz system clock.
*/
package slpo_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [12:0] TEACH_ON_MS = 13'h0064;
  localparam logic [12:0] TEACH_OFF_MS = 13'h0064;
  localparam logic [12:0] UPPER_MS = 13'h007d;
  localparam logic [12:0] LOWER_MS = 13'h00fa;
  localparam logic [12:0] SLOW_MS = 13'h01f4;
  localparam logic [12:0] LONG_MS = 13'h01c2;
  localparam logic [12:0] SHORT_MS = 13'h0032;
  localparam logic [12:0] MAINT_ON_MS = 13'h03e8;
  localparam logic [12:0] MAINT_OFF_MS = 13'h0bb8;
  localparam logic [12:0] HOLD_MS = 13'h0bb8;
  localparam logic [1:0] BURST_COUNT = 2'h3;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] EVT_OFS = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Control bits.
  localparam int CTRL_OVR_EN = 0;
  localparam int CTRL_MANUAL = 1;
  localparam int CTRL_PV1 = 2;
  localparam int CTRL_MAINT_EN = 3;
  localparam int CTRL_AS_VARIANT = 4;
  localparam int CTRL_SERVICE = 5;

  // Lamp colours.
  typedef enum logic [1:0] {
    SLPO_OFF,
    SLPO_GREEN,
    SLPO_YELLOW,
    SLPO_RED
  } slpo_colour_t;

  // Condition inputs from the valve and teach logic.
  typedef struct packed {
    logic closed;
    logic open;
    logic upper_lift;
    logic lower_lift;
    logic slow_fault;
    logic internal_fault;
    logic maint_due;
  } slpo_cond_t;

  // One-cycle events from the teach logic.
  typedef struct packed {
    logic teach_ok;
    logic no_target;
    logic too_close;
  } slpo_evt_t;

endpackage

//--- src/slpo_top.sv
/*
  Status lamp pattern generator with magnetic manual override of pilot
  valve one, reached by software over AXI4-Lite.
  Assumes condition and event inputs are synchronous to mclk, while the
  magnet sensor and colour switches are asynchronous pins.
*/
// Functional notes
// - Steady valve-state colour when nothing else applies.
// - Teach success: three 100 ms blinks, state colour.
// - Target not found: three fault-colour blinks.
// - Position within 0.5 mm: reject, three fault blinks.
// - Override while disabled: ignore, three fault blinks.
// - Upper seat lift: 125/125 ms open colour.
// - Lower seat lift: 250/250 ms open colour.
// - Listed fault conditions: fault-colour blinking, 500/500 ms slow fault, 450/50 ms internal fault.
// - Service or override: 50 on, 450 off.
// - Maintenance due: 1 s on, 3 s showing position.
// - Automatic mode override forces pilot one on.
// - Override ignored in manual mode.
// - Override never turns pilot one off.
// - Override enable register, default enabled.
// - Override active reports fault bit or mode.
// - Position feedback unchanged while override active.
// - Three-second magnet hold toggles override.
// - Power-up clears override, standard mode.
// - Colour switches select closed/open/fault colours.
`timescale 1ns/100ps
module slpo_top
  import slpo_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire slpo_cond_t cond,
  input wire slpo_evt_t evt,
  input wire logic magnet_pin,
  input wire logic colour_select_lo,
  input wire logic colour_select_hi,
  output slpo_colour_t status_lamp,
  output logic pilot_valve_one,
  output logic fault_bit,
  output logic manual_mode_active,
  output logic position_feedback
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;

  // Two flops on every asynchronous pin.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {magnet_pin, colour_select_hi, colour_select_lo};
      sync2 <= sync1;
    end
  end

  wire logic magnet = sync2[2];

  // ------------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------------
  logic [31:0] div_cnt;
  logic tick;

  // Divides the clock down to a one-cycle pulse per millisecond.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == TICK_DIV - 1);
      div_cnt <= (div_cnt == TICK_DIV - 1) ? 32'h0 : div_cnt + 32'h1;
    end
  end

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [2:0] evt_seen;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic override;
  logic burst_busy;

  wire logic wr_go = aw_held && w_held && !s_axi_bvalid;

  // Write channel: address and data taken independently, then answered.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == CTRL_OFS || aw_addr == EVT_OFS) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Control register; the override enable resets to enabled.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (wr_go && aw_addr == CTRL_OFS && w_strb[0]) begin
      ctrl[7:0] <= w_data[7:0];
    end
  end

  // Sticky teach event record; a new event wins over a clear.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evt_seen <= 3'h0;
    end else begin
      evt_seen <= (evt_seen & ~((wr_go && aw_addr == EVT_OFS) ? w_data[2:0] : 3'h0))
                  | {evt.too_close, evt.no_target, evt.teach_ok};
    end
  end

  // Read channel.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          CTRL_OFS: s_axi_rdata <= {24'h0, ctrl[7:0]};
          STAT_OFS: s_axi_rdata <= {26'h0, sync2[1:0], burst_busy, pilot_valve_one,
                                    manual_mode_active, override};
          EVT_OFS: s_axi_rdata <= {29'h0, evt_seen};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Magnetic override
  // ------------------------------------------------------------------
  logic [12:0] hold_ms;
  logic hold_done;
  logic refuse_evt;
  wire logic hold_full = tick && hold_ms == HOLD_MS - 13'h1;

  // Counts a continuous magnet hold; a release restarts the count.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_ms <= 13'h0;
      hold_done <= 1'b0;
    end else if (!magnet) begin
      hold_ms <= 13'h0;
      hold_done <= 1'b0;
    end else if (hold_full && !hold_done) begin
      hold_done <= 1'b1;
    end else if (tick && !hold_done) begin
      hold_ms <= hold_ms + 13'h1;
    end
  end

  // Toggles the override once per full hold, cleared by power-up reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      override <= 1'b0;
      refuse_evt <= 1'b0;
    end else begin
      refuse_evt <= 1'b0;
      if (ctrl[CTRL_MANUAL]) begin
        override <= 1'b0;
      end else if (hold_full && !hold_done) begin
        if (ctrl[CTRL_OVR_EN]) begin
          override <= !override;
        end else begin
          refuse_evt <= 1'b1;
        end
      end else if (!ctrl[CTRL_OVR_EN]) begin
        override <= 1'b0;
      end
    end
  end

  // Pilot one follows the controller, ORed with the override.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pilot_valve_one <= 1'b0;
      fault_bit <= 1'b0;
      manual_mode_active <= 1'b0;
    end else begin
      pilot_valve_one <= ctrl[CTRL_PV1] | override;
      fault_bit <= override && ctrl[CTRL_AS_VARIANT];
      manual_mode_active <= override && !ctrl[CTRL_AS_VARIANT];
    end
  end

  // ------------------------------------------------------------------
  // Lamp patterns
  // ------------------------------------------------------------------
  slpo_colour_t col_closed;
  slpo_colour_t col_open;
  slpo_colour_t col_fault;
  logic [5:0] col_word;

  // Colour switch decode into one packed word of closed, open and fault colours.
  always_comb begin
    unique case (sync2[1:0])
      2'b00: col_word = {SLPO_GREEN, SLPO_YELLOW, SLPO_RED};
      2'b01: col_word = {SLPO_YELLOW, SLPO_GREEN, SLPO_RED};
      2'b10: col_word = {SLPO_GREEN, SLPO_RED, SLPO_YELLOW};
      2'b11: col_word = {SLPO_RED, SLPO_GREEN, SLPO_YELLOW};
    endcase
  end

  // Each colour is cast back out of the word, so no enum is written as a slice.
  assign col_closed = slpo_colour_t'(col_word[5:4]);
  assign col_open = slpo_colour_t'(col_word[3:2]);
  assign col_fault = slpo_colour_t'(col_word[1:0]);

  slpo_colour_t state_col;
  assign state_col = cond.open ? col_open : (cond.closed ? col_closed : SLPO_OFF);

  // Three-blink burst sequencer.
  logic [1:0] burst_left;
  logic burst_on;
  logic [12:0] burst_ms;
  slpo_colour_t burst_col;
  wire logic fault_evt = evt.no_target || evt.too_close || refuse_evt;

  // Bursts run to completion; a new event is taken only when idle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      burst_left <= 2'h0;
      burst_on <= 1'b0;
      burst_ms <= 13'h0;
      burst_col <= SLPO_OFF;
    end else if (!burst_busy && (evt.teach_ok || fault_evt)) begin
      burst_left <= BURST_COUNT;
      burst_on <= 1'b1;
      burst_ms <= 13'h0;
      burst_col <= fault_evt ? col_fault : state_col;
    end else if (burst_busy && tick) begin
      if (burst_ms == (burst_on ? TEACH_ON_MS : TEACH_OFF_MS) - 13'h1) begin
        burst_ms <= 13'h0;
        burst_on <= !burst_on;
        if (!burst_on) begin
          burst_left <= burst_left - 2'h1;
        end
      end else begin
        burst_ms <= burst_ms + 13'h1;
      end
    end
  end

  assign burst_busy = burst_left != 2'h0;

  // Continuous pattern selection, highest priority first.
  logic [12:0] pat_on;
  logic [12:0] pat_off;
  logic pat_blink;
  logic pat_fault;
  logic pat_maint;
  always_comb begin
    pat_on = 13'h0;
    pat_off = 13'h0;
    pat_blink = 1'b1;
    pat_fault = 1'b1;
    pat_maint = 1'b0;
    if (cond.internal_fault) begin
      pat_on = LONG_MS;
      pat_off = SHORT_MS;
    end else if (cond.slow_fault) begin
      pat_on = SLOW_MS;
      pat_off = SLOW_MS;
    end else if (override || ctrl[CTRL_SERVICE]) begin
      pat_on = SHORT_MS;
      pat_off = LONG_MS;
    end else if (cond.maint_due && ctrl[CTRL_MAINT_EN]) begin
      pat_on = MAINT_ON_MS;
      pat_off = MAINT_OFF_MS;
      pat_maint = 1'b1;
    end else if (cond.upper_lift) begin
      pat_on = UPPER_MS;
      pat_off = UPPER_MS;
      pat_fault = 1'b0;
    end else if (cond.lower_lift) begin
      pat_on = LOWER_MS;
      pat_off = LOWER_MS;
      pat_fault = 1'b0;
    end else begin
      pat_blink = 1'b0;
      pat_fault = 1'b0;
    end
  end

  // Free-running phase of the continuous pattern.
  logic pat_phase;
  logic [12:0] pat_ms;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pat_phase <= 1'b1;
      pat_ms <= 13'h0;
    end else if (!pat_blink) begin
      pat_phase <= 1'b1;
      pat_ms <= 13'h0;
    end else if (tick) begin
      if (pat_ms >= (pat_phase ? pat_on : pat_off) - 13'h1) begin
        pat_ms <= 13'h0;
        pat_phase <= !pat_phase;
      end else begin
        pat_ms <= pat_ms + 13'h1;
      end
    end
  end

  // Lamp output; bursts take precedence over every continuous pattern.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_lamp <= SLPO_OFF;
    end else if (burst_busy) begin
      status_lamp <= burst_on ? burst_col : SLPO_OFF;
    end else if (pat_maint && !pat_phase) begin
      status_lamp <= state_col;
    end else if (pat_phase) begin
      status_lamp <= pat_fault ? col_fault : (pat_blink ? col_open : state_col);
    end else begin
      status_lamp <= SLPO_OFF;
    end
  end

  // Position feedback tracks the valve regardless of the override.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      position_feedback <= 1'b0;
    end else begin
      position_feedback <= cond.open;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_pilot_forced: assert property (@(posedge mclk) disable iff (rst)
    override |=> pilot_valve_one)
    else $error("Override did not force pilot one on.");

  chk_pilot_not_off: assert property (@(posedge mclk) disable iff (rst)
    ctrl[CTRL_PV1] ##1 ctrl[CTRL_PV1] |-> pilot_valve_one)
    else $error("Commanded pilot one turned off.");

  chk_manual_ignores: assert property (@(posedge mclk) disable iff (rst)
    ctrl[CTRL_MANUAL] |=> !override)
    else $error("Override active in manual mode.");

  chk_toggle_hold: assert property (@(posedge mclk) disable iff (rst)
    $changed(override) && !$past(ctrl[CTRL_MANUAL]) && $past(ctrl[CTRL_OVR_EN])
      |-> $past(hold_full))
    else $error("Override changed without a full hold.");

  chk_refuse_disabled: assert property (@(posedge mclk) disable iff (rst)
    hold_full && !hold_done && !ctrl[CTRL_OVR_EN] && !ctrl[CTRL_MANUAL] |=> refuse_evt)
    else $error("Disabled override not refused.");

  chk_report_mode: assert property (@(posedge mclk) disable iff (rst)
    override && $stable(override) && $stable(ctrl[CTRL_AS_VARIANT])
      |-> (fault_bit == ctrl[CTRL_AS_VARIANT]) && (manual_mode_active != fault_bit))
    else $error("Override not reported.");

  chk_burst_start: assert property (@(posedge mclk) disable iff (rst)
    !burst_busy && evt.teach_ok |=> burst_left == BURST_COUNT && burst_on)
    else $error("Teach burst did not start.");

  chk_burst_shows: assert property (@(posedge mclk) disable iff (rst)
    burst_busy && burst_on |=> status_lamp == $past(burst_col))
    else $error("Burst not shown on lamp.");

  chk_feedback: assert property (@(posedge mclk) disable iff (rst)
    ##1 position_feedback == $past(cond.open))
    else $error("Position feedback not following valve.");

endmodule

//--- verif/slpo_fb_ctrl.sv
/*
  Fieldbus controller model: an AXI4-Lite master offering one write task and one read task.
  Assumes the slave shares mclk and answers in its own time; only the bench watchdog ends a wait.
*/
`timescale 1ns/100ps
module slpo_fb_ctrl (
  input wire logic mclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Every request line starts released.
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Address and data go out together; each is dropped at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // The read data and response are taken at the edge that shows rvalid.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

//--- verif/slpo_top_tb_top.sv
/*
  Self-checking bench for the lamp pattern and magnetic override block.
  Assumes TICK_DIV is cut to 2, so one millisecond is two clocks.
*/
`timescale 1ns/100ps
module slpo_top_tb_top
  import slpo_pkg::*;
;
  localparam int TD = 2;
  logic mclk, rst, magnet_pin, colour_select_lo, colour_select_hi, seen;
  slpo_cond_t cond;
  slpo_evt_t evt;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pilot_valve_one, fault_bit, manual_mode_active, position_feedback;
  slpo_colour_t status_lamp;
  slpo_colour_t tbl [4][3];
  int n_errors, n_tests, seed;

  slpo_top #(.TICK_DIV(TD)) uut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cond, .evt, .magnet_pin, .colour_select_lo,
    .colour_select_hi, .status_lamp, .pilot_valve_one, .fault_bit, .manual_mode_active,
    .position_feedback);

  slpo_fb_ctrl bus (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;

  // Any fault-red lamp since the last clear is remembered.
  always @(posedge mclk) if (status_lamp === SLPO_RED) seen <= 1'b1;

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_col(input slpo_colour_t g, input slpo_colour_t e);
    chk_val(32'(g), 32'(e));
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic end_test(input string s);
    $display("test %s done, mismatches %0d", s, n_errors);
  endtask

  // The magnet is held for the given number of milliseconds.
  task automatic hold(input int ms);
    magnet_pin <= 1'b1;
    wt(ms * TD);
    magnet_pin <= 1'b0;
    wt(8);
  endtask

  // Three blinks of 100 ms on, 100 ms off, sampled mid-phase, then steady again.
  task automatic burst(input logic [2:0] e, input slpo_colour_t c, input slpo_colour_t st);
    evt <= e;
    wt(1);
    evt <= '0;
    for (int i = 0; i < 3; i++) begin
      wt(50 * TD);
      chk_col(status_lamp, c);
      wt(100 * TD);
      chk_col(status_lamp, SLPO_OFF);
      wt(50 * TD);
    end
    wt(20);
    chk_col(status_lamp, st);
  endtask

  // Bounded wait while the lamp equals (eq) or differs from colour k.
  task automatic wl(input slpo_colour_t k, input logic eq, output int n);
    n = 0;
    while (((status_lamp === k) == eq) && n < 20000) begin
      @(posedge mclk);
      n++;
    end
  endtask

  // One full on/off period of a continuous pattern is timed and compared.
  task automatic pat(input logic [6:0] c, input logic [31:0] ct, input slpo_colour_t k,
                     input int on, input int off, input slpo_colour_t oc);
    int n1;
    int n2;
    slpo_colour_t ov;
    bus.wr(CTRL_OFS, ct, r);
    cond <= c;
    wt(4);
    wl(k, 1'b0, n1);
    wl(k, 1'b1, n1);
    wl(k, 1'b0, n1);
    wl(k, 1'b1, n1);
    ov = status_lamp;
    wl(k, 1'b0, n2);
    chk_val(n1, on * TD);
    chk_val(n2, off * TD);
    chk_col(ov, oc);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // A hang is cut short at 95000 cycles, above the longest expected run.
  initial begin
    #950000;
    n_errors++;
    give_verdict();
  end

  // Main sequence: registers, colours, bursts, patterns, override.
  initial begin
    tbl = '{'{SLPO_GREEN, SLPO_YELLOW, SLPO_RED}, '{SLPO_YELLOW, SLPO_GREEN, SLPO_RED},
            '{SLPO_GREEN, SLPO_RED, SLPO_YELLOW}, '{SLPO_RED, SLPO_GREEN, SLPO_YELLOW}};
    {mclk, magnet_pin, colour_select_lo, colour_select_hi, seen} = '0;
    cond = '0;
    evt = '0;
    rst = 1'b1;
    n_errors = 0;
    n_tests = 0;
    seed = 32'h750f;
    wt(8);
    rst <= 1'b0;
    bus.rd(CTRL_OFS, q, r);
    chk_val(q, CTRL_RESET);
    bus.rd(STAT_OFS, q, r);
    chk_val(q[0], 1'b0);
    bus.rd(8'h0c, q, r);
    chk_val(r, 2'h2);
    v = ($random(seed) & 32'h3e) | 32'h1;
    bus.wr(CTRL_OFS, v, r);
    chk_val(r, 2'h0);
    bus.rd(CTRL_OFS, q, r);
    chk_val(q, v);
    bus.wr(8'h0c, 32'h0, r);
    chk_val(r, 2'h2);
    bus.wr(CTRL_OFS, CTRL_RESET, r);
    end_test("registers");
    for (int s = 0; s < 4; s++) begin
      colour_select_lo <= s[0];
      colour_select_hi <= s[1];
      cond <= 7'h40;
      wt(20);
      chk_col(status_lamp, tbl[s][0]);
      cond <= 7'h20;
      wt(20);
      chk_col(status_lamp, tbl[s][1]);
      burst(3'h4, tbl[s][1], tbl[s][1]);
      burst(3'h2, tbl[s][2], tbl[s][1]);
      burst(3'h1, tbl[s][2], tbl[s][1]);
    end
    colour_select_lo <= 1'b0;
    colour_select_hi <= 1'b0;
    bus.rd(EVT_OFS, q, r);
    chk_val(q, 32'h7);
    bus.wr(EVT_OFS, 32'h7, r);
    bus.rd(EVT_OFS, q, r);
    chk_val(q, 32'h0);
    end_test("colours and bursts");
    pat(7'h10, 32'h1, SLPO_YELLOW, 125, 125, SLPO_OFF);
    pat(7'h08, 32'h1, SLPO_YELLOW, 250, 250, SLPO_OFF);
    pat(7'h04, 32'h1, SLPO_RED, 500, 500, SLPO_OFF);
    pat(7'h02, 32'h1, SLPO_RED, 450, 50, SLPO_OFF);
    pat(7'h12, 32'h1, SLPO_RED, 450, 50, SLPO_OFF);
    pat(7'h40, 32'h21, SLPO_RED, 50, 450, SLPO_OFF);
    pat(7'h41, 32'h9, SLPO_RED, 1000, 3000, SLPO_GREEN);
    end_test("patterns");
    bus.wr(CTRL_OFS, 32'h11, r);
    cond <= 7'h20;
    hold(500 + ($random(seed) & 32'h7ff));
    bus.rd(STAT_OFS, q, r);
    chk_val(q[0], 1'b0);
    hold(3050);
    bus.rd(STAT_OFS, q, r);
    chk_val(q[0], 1'b1);
    chk_val(pilot_valve_one, 1'b1);
    chk_val({fault_bit, manual_mode_active}, 2'h2);
    chk_val(position_feedback, 1'b1);
    pat(7'h40, 32'h11, SLPO_RED, 50, 450, SLPO_OFF);
    chk_val(position_feedback, 1'b0);
    bus.wr(CTRL_OFS, 32'h5, r);
    wt(4);
    chk_val({fault_bit, manual_mode_active}, 2'h1);
    hold(3050);
    bus.rd(STAT_OFS, q, r);
    chk_val(q[0], 1'b0);
    chk_val(pilot_valve_one, 1'b1);
    bus.wr(CTRL_OFS, 32'h3, r);
    hold(3050);
    bus.rd(STAT_OFS, q, r);
    chk_val({q[0], pilot_valve_one}, 2'h0);
    bus.wr(CTRL_OFS, 32'h0, r);
    seen = 1'b0;
    hold(3050);
    wt(700 * TD);
    bus.rd(STAT_OFS, q, r);
    chk_val({q[0], seen}, 2'h1);
    bus.wr(CTRL_OFS, 32'h1, r);
    hold(3050);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(4);
    chk_val(pilot_valve_one, 1'b0);
    bus.rd(STAT_OFS, q, r);
    chk_val(q[0], 1'b0);
    bus.rd(CTRL_OFS, q, r);
    chk_val(q, CTRL_RESET);
    end_test("override");
    give_verdict();
  end
endmodule
